// ===== inc/ttrb_pkg.sv
// Shared constants for the 16-bit reload and baud-rate timer.
// Assumes one oscillator clock; all slower rates are enable pulses.
package ttrb_pkg;

  // Count limits and reset value.
  localparam logic [15:0] TTRB_COUNT_MAX   = 16'hFFFF;
  localparam logic [15:0] TTRB_COUNT_RST   = 16'h0000;
  // Machine cycle is twelve oscillator clocks: prescaler 0 to 11.
  localparam logic [3:0]  TTRB_PRESC_LAST  = 4'hB;
  localparam logic [3:0]  TTRB_PRESC_RST   = 4'h0;
  // Serial bit rate is the selected overflow rate divided by sixteen.
  localparam logic [3:0]  TTRB_BAUD_LAST   = 4'hF;
  localparam logic [3:0]  TTRB_BAUD_RST    = 4'h0;
  // Pins idle high, so synchronisers reset high to avoid a false edge.
  localparam logic [1:0]  TTRB_PIN_IDLE    = 2'h3;
  // Bit positions in the synchronised pin vector.
  localparam int          TTRB_PIN_TRIG    = 0;
  localparam int          TTRB_PIN_COUNT   = 1;
  // Channel positions for the serial clock selects and ticks.
  localparam int          TTRB_CH_RX       = 0;
  localparam int          TTRB_CH_TX       = 1;
  localparam int          TTRB_CHANNELS    = 2;

  // Operating behaviour chosen from the control inputs.
  typedef enum logic [1:0] {
    TTRB_MODE_UP,
    TTRB_MODE_UPDOWN,
    TTRB_MODE_BAUD
  } ttrb_mode_t;

endpackage

// ===== inc/ttrb_sync_if.sv
// Carrier for synchronised pin levels and their falling-edge pulses.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface ttrb_sync_if;
  logic [1:0] level;
  logic [1:0] fall;
  modport src (output level, output fall);
  modport dst (input level, input fall);
endinterface

// ===== rtl/ttrb_sync.sv
// Two-flop synchronisers and falling-edge detection for the trigger
// and external count pins.
// Assumes pins are asynchronous to core_clk and idle high.
`timescale 1ns/1ps
module ttrb_sync (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic [1:0] pins,
  ttrb_sync_if.src        sync
);

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
    logic [1:0] prev;
  } ttrb_sync_state_t;

  ttrb_sync_state_t state_reg;
  ttrb_sync_state_t state_next;

  // sync before edges.
  // The first stage feeds only the second; edges look at later stages.
  always_comb begin
    state_next        = state_reg;
    state_next.meta   = pins;
    state_next.stable = state_reg.meta;
    state_next.prev   = state_reg.stable;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '{meta:   ttrb_pkg::TTRB_PIN_IDLE,
                     stable: ttrb_pkg::TTRB_PIN_IDLE,
                     prev:   ttrb_pkg::TTRB_PIN_IDLE};
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from flip-flops and a single gate.
  assign sync.level = state_reg.stable;
  assign sync.fall  = state_reg.prev & ~state_reg.stable;

  edge_once_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (sync.fall != 2'h0) |=> ((sync.fall & $past(sync.fall)) == 2'h0))
    else $error("Falling edge reported on two cycles in a row.");

endmodule

// ===== rtl/ttrb_timer.sv
// Sixteen-bit auto-reload timer with baud-rate generator behaviour.
// Assumes core_clk is the oscillator; control bits and reload bytes
// are held by software elsewhere and arrive as plain ports.
`timescale 1ns/1ps
module ttrb_timer (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       run_control,
  input  wire logic       counter_timer_select,
  input  wire logic       down_count_enable,
  input  wire logic       ext_trigger_enable,
  input  wire logic       tx_clock_select,
  input  wire logic       rx_clock_select,
  input  wire logic       timer_irq_enable,
  input  wire logic [7:0] reload_low_byte,
  input  wire logic [7:0] reload_high_byte,
  input  wire logic       count_wr_en,
  input  wire logic [15:0] count_wr_data,
  input  wire logic       overflow_flag_clr,
  input  wire logic       external_flag_clr,
  input  wire logic       trigger_direction_input,
  input  wire logic       external_count_input,
  input  wire logic       timer1_overflow,
  output logic      [7:0] count_low_byte,
  output logic      [7:0] count_high_byte,
  output logic            overflow_flag,
  output logic            external_flag,
  output logic            timer_irq,
  output logic            timer2_overflow,
  output logic            rx_baud_tick,
  output logic            tx_baud_tick
);

  typedef struct packed {
    logic [15:0]     count;
    logic            ovf_flag;
    logic            ext_flag;
    logic [3:0]      presc;
    logic            ovf_pulse;
    logic [1:0][3:0] div;
    logic [1:0]      bit_tick;
  } ttrb_state_t;

  ttrb_state_t          state_reg;
  ttrb_state_t          state_next;
  ttrb_pkg::ttrb_mode_t mode;
  logic [15:0]          reload;
  logic [1:0]           clk_sel;
  logic [1:0]           ch_src;
  logic                 baud_mode;
  logic                 mach_tick;
  logic                 state_tick;
  logic                 int_step;
  logic                 cnt_step;
  logic                 count_up;
  logic                 trig_evt;
  logic                 wrap_up;
  logic                 wrap_dn;
  logic                 of_set;
  logic                 ef_set;
  logic                 ef_tog;

  ttrb_sync_if sync_bus ();

  // Pin order matches the trigger and count positions in the package.
  ttrb_sync u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pins     ({external_count_input, trigger_direction_input}),
    .sync     (sync_bus.src)
  );

  assign reload    = {reload_high_byte, reload_low_byte};
  assign clk_sel   = {tx_clock_select, rx_clock_select};
  assign baud_mode = tx_clock_select | rx_clock_select;

  // Mode decode: any serial clock select forces baud behaviour.
  always_comb begin
    if (baud_mode) begin
      mode = ttrb_pkg::TTRB_MODE_BAUD;
    end else if (down_count_enable) begin
      mode = ttrb_pkg::TTRB_MODE_UPDOWN;
    end else begin
      mode = ttrb_pkg::TTRB_MODE_UP;
    end
  end

  // Step and wrap decode, shared by every mode.
  always_comb begin
    mach_tick  = (state_reg.presc == ttrb_pkg::TTRB_PRESC_LAST);
    state_tick = state_reg.presc[0];
    // state-time rate.
    // Baud mode uses every second clock rather than every twelfth.
    int_step   = baud_mode ? state_tick : mach_tick;
    cnt_step   = run_control & (counter_timer_select
                 ? sync_bus.fall[ttrb_pkg::TTRB_PIN_COUNT] : int_step);
    // up by default.
    // Direction follows the trigger level only in up/down mode.
    count_up   = (mode != ttrb_pkg::TTRB_MODE_UPDOWN)
                 | sync_bus.level[ttrb_pkg::TTRB_PIN_TRIG];
    trig_evt   = ext_trigger_enable
                 & sync_bus.fall[ttrb_pkg::TTRB_PIN_TRIG];
    wrap_up    = cnt_step & count_up
                 & (state_reg.count == ttrb_pkg::TTRB_COUNT_MAX);
    wrap_dn    = cnt_step & ~count_up & (state_reg.count == reload);
  end

  // Next-state logic for count, flags, prescaler and serial dividers.
  always_comb begin
    state_next = state_reg;
    of_set     = 1'b0;
    ef_set     = 1'b0;
    ef_tog     = 1'b0;
    ch_src     = 2'h0;
    state_next.presc = mach_tick ? ttrb_pkg::TTRB_PRESC_RST
                     : 4'(state_reg.presc + 4'h1);
    unique case (mode)
      ttrb_pkg::TTRB_MODE_BAUD: begin
        if (wrap_up) begin
          state_next.count = reload;
        end else if (cnt_step) begin
          state_next.count = 16'(state_reg.count + 16'h0001);
        end
        ef_set = trig_evt;
      end
      ttrb_pkg::TTRB_MODE_UPDOWN: begin
        if (wrap_up) begin
          state_next.count = reload;
        end else if (wrap_dn) begin
          state_next.count = ttrb_pkg::TTRB_COUNT_MAX;
        end else if (cnt_step) begin
          state_next.count = count_up
            ? 16'(state_reg.count + 16'h0001)
            : 16'(state_reg.count - 16'h0001);
        end
        of_set = wrap_up | wrap_dn;
        ef_tog = wrap_up | wrap_dn;
      end
      ttrb_pkg::TTRB_MODE_UP: begin
        if (wrap_up | trig_evt) begin
          state_next.count = reload;
        end else if (cnt_step) begin
          state_next.count = 16'(state_reg.count + 16'h0001);
        end
        of_set = wrap_up;
        ef_set = trig_evt;
      end
    endcase
    // software write.
    // A direct write wins over counting; software must stop the timer
    // first in baud mode, otherwise a reload can be lost.
    if (count_wr_en) begin
      state_next.count = count_wr_data;
    end
    // Hardware events win over a software clear in the same cycle.
    state_next.ovf_flag = (state_reg.ovf_flag & ~overflow_flag_clr)
                          | of_set;
    state_next.ext_flag = ((state_reg.ext_flag & ~external_flag_clr)
                          | ef_set) ^ ef_tog;
    // Overflow pulses reach the serial port only in baud mode.
    state_next.ovf_pulse = baud_mode & wrap_up;
    for (int ch = 0; ch < ttrb_pkg::TTRB_CHANNELS; ch++) begin
      ch_src[ch] = clk_sel[ch] ? state_reg.ovf_pulse : timer1_overflow;
      if (ch_src[ch]) begin
        state_next.div[ch] = 4'(state_reg.div[ch] + 4'h1);
      end
      state_next.bit_tick[ch] = ch_src[ch]
        & (state_reg.div[ch] == ttrb_pkg::TTRB_BAUD_LAST);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '{count:     ttrb_pkg::TTRB_COUNT_RST,
                     ovf_flag:  1'b0,
                     ext_flag:  1'b0,
                     presc:     ttrb_pkg::TTRB_PRESC_RST,
                     ovf_pulse: 1'b0,
                     div:       {ttrb_pkg::TTRB_BAUD_RST,
                                 ttrb_pkg::TTRB_BAUD_RST},
                     bit_tick:  2'h0};
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs from the state register.
  assign count_low_byte  = state_reg.count[7:0];
  assign count_high_byte = state_reg.count[15:8];
  assign overflow_flag   = state_reg.ovf_flag;
  assign external_flag   = state_reg.ext_flag;
  assign timer2_overflow = state_reg.ovf_pulse;
  assign rx_baud_tick    = state_reg.bit_tick[ttrb_pkg::TTRB_CH_RX];
  assign tx_baud_tick    = state_reg.bit_tick[ttrb_pkg::TTRB_CH_TX];

  // no interrupt.
  // In up/down mode the external flag is a count bit, not an event.
  assign timer_irq = timer_irq_enable
                     & (state_reg.ovf_flag
                        | (state_reg.ext_flag & ~down_count_enable));

  up_reload_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (mode == ttrb_pkg::TTRB_MODE_UP && wrap_up && !count_wr_en)
    |=> ({count_high_byte, count_low_byte} == $past(reload))
        && overflow_flag)
    else $error("Up overflow did not reload and set the flag.");

  trig_reload_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (mode == ttrb_pkg::TTRB_MODE_UP && trig_evt && !count_wr_en)
    |=> ({count_high_byte, count_low_byte} == $past(reload))
        && external_flag)
    else $error("Trigger fall did not reload and set external flag.");

  irq_raise_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (timer_irq_enable && !down_count_enable
     && (overflow_flag || external_flag)) |-> timer_irq)
    else $error("Set flag did not raise the interrupt.");

  down_wrap_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (mode == ttrb_pkg::TTRB_MODE_UPDOWN && wrap_dn && !count_wr_en)
    |=> ({count_high_byte, count_low_byte} == ttrb_pkg::TTRB_COUNT_MAX)
        && overflow_flag)
    else $error("Underflow did not load all ones and set the flag.");

  // A clear in the wrap cycle is applied first, then the toggle.
  ext_toggle_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (mode == ttrb_pkg::TTRB_MODE_UPDOWN && (wrap_up || wrap_dn))
    |=> (external_flag
         != ($past(external_flag) && !$past(external_flag_clr))))
    else $error("External flag did not toggle on wrap.");

  updown_ovf_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (mode == ttrb_pkg::TTRB_MODE_UPDOWN && wrap_up && !count_wr_en)
    |=> ({count_high_byte, count_low_byte} == $past(reload))
        && overflow_flag)
    else $error("Up/down overflow did not reload and set the flag.");

  baud_reload_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (baud_mode && wrap_up && !count_wr_en)
    |=> ({count_high_byte, count_low_byte} == $past(reload))
        && timer2_overflow)
    else $error("Baud rollover did not reload and pulse overflow.");

  bit_tick_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    tx_baud_tick |-> ($past(state_reg.div[ttrb_pkg::TTRB_CH_TX])
                      == ttrb_pkg::TTRB_BAUD_LAST)
                     && $past(ch_src[ttrb_pkg::TTRB_CH_TX]))
    else $error("Transmit bit tick not on sixteenth source pulse.");

  state_rate_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    state_tick |=> !state_tick ##1 state_tick)
    else $error("State-time tick not every second clock.");

  baud_noflag_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (baud_mode && !overflow_flag) |=> !overflow_flag)
    else $error("Baud mode set the overflow flag.");

  baud_trig_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (baud_mode && trig_evt && !cnt_step && !count_wr_en)
    |=> external_flag && $stable({count_high_byte, count_low_byte}))
    else $error("Baud mode trigger reloaded or missed the flag.");

  run_stop_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (!run_control && !count_wr_en && !trig_evt)
    |=> $stable({count_high_byte, count_low_byte}))
    else $error("Count moved while stopped.");

endmodule

// ===== verif/ttrb_serial_model.sv
// Behavioural serial port that stands beyond the timer's baud outputs.
// Assumes one core_clk; timer 1 overflows come at a fixed period.
`timescale 1ns/1ps
module ttrb_serial_model #(
  parameter int T1_PERIOD = 20
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        cnt_clr,
  input  wire logic        rx_baud_tick,
  input  wire logic        tx_baud_tick,
  output logic             timer1_overflow,
  output logic      [15:0] rx_seen,
  output logic      [15:0] tx_seen
);
  int t1_cnt;

  // Timer 1 is modelled as a free-running divider with one-cycle pulses.
  // other timer source
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      t1_cnt          <= 0;
      timer1_overflow <= 1'b0;
    end else begin
      t1_cnt          <= (t1_cnt == T1_PERIOD - 1) ? 0 : t1_cnt + 1;
      timer1_overflow <= (t1_cnt == T1_PERIOD - 1);
    end
  end

  // Bit ticks are counted so the bench can judge both channel rates.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_seen <= 16'h0000;
      tx_seen <= 16'h0000;
    end else if (cnt_clr) begin
      rx_seen <= 16'h0000;
      tx_seen <= 16'h0000;
    end else begin
      rx_seen <= rx_seen + {15'h0000, rx_baud_tick};
      tx_seen <= tx_seen + {15'h0000, tx_baud_tick};
    end
  end
endmodule

// ===== verif/ttrb_timer_bench.sv
// Self-checking bench for the reload and baud-rate timer.
// Assumes the serial model feeds timer 1 overflows and counts bit ticks.
`timescale 1ns/1ps
module ttrb_timer_bench;
  typedef struct packed {
    logic        dce;
    logic        trig;
    logic [15:0] rld;
    logic [15:0] pre;
    logic [15:0] nxt;
    logic        ovf;
    logic        ext;
  } ttrb_row_t;

  logic core_clk = 1'b0, rstn = 1'b0, run_control = 1'b0;
  logic counter_timer_select = 1'b0, down_count_enable = 1'b0;
  logic ext_trigger_enable = 1'b0, tx_clock_select = 1'b0;
  logic rx_clock_select = 1'b0, timer_irq_enable = 1'b1;
  logic [7:0] reload_low_byte = 8'h00, reload_high_byte = 8'h00;
  logic count_wr_en = 1'b0, overflow_flag_clr = 1'b0;
  logic [15:0] count_wr_data = 16'h0000;
  logic external_flag_clr = 1'b0, trigger_direction_input = 1'b1;
  logic external_count_input = 1'b1, timer1_overflow, cnt_clr = 1'b0;
  logic [7:0] count_low_byte, count_high_byte;
  logic overflow_flag, external_flag, timer_irq, timer2_overflow;
  logic rx_baud_tick, tx_baud_tick;
  logic [15:0] rx_seen, tx_seen, cnt;
  int err_total = 0, n_compared = 0, n_t2 = 0, gap;
  ttrb_row_t rows [5] = '{
    '{1'b0, 1'b1, 16'h1234, 16'hFFFF, 16'h1234, 1'b1, 1'b0},
    '{1'b0, 1'b1, 16'h1234, 16'h0010, 16'h0011, 1'b0, 1'b0},
    '{1'b1, 1'b1, 16'hABCD, 16'hFFFF, 16'hABCD, 1'b1, 1'b1},
    '{1'b1, 1'b0, 16'hABCD, 16'hABCD, 16'hFFFF, 1'b1, 1'b1},
    '{1'b1, 1'b0, 16'h0000, 16'h0005, 16'h0004, 1'b0, 1'b0}};

  assign cnt = {count_high_byte, count_low_byte};

  always #5 core_clk = ~core_clk;

  // Overflow pulses are counted to measure the baud-mode wrap rate.
  always @(posedge core_clk) begin
    if (cnt_clr) n_t2 <= 0;
    else if (timer2_overflow === 1'b1) n_t2 <= n_t2 + 1;
  end

  ttrb_timer ttrb_timer_inst (
    .core_clk(core_clk), .rstn(rstn), .run_control(run_control),
    .counter_timer_select(counter_timer_select),
    .down_count_enable(down_count_enable),
    .ext_trigger_enable(ext_trigger_enable),
    .tx_clock_select(tx_clock_select), .rx_clock_select(rx_clock_select),
    .timer_irq_enable(timer_irq_enable),
    .reload_low_byte(reload_low_byte), .reload_high_byte(reload_high_byte),
    .count_wr_en(count_wr_en), .count_wr_data(count_wr_data),
    .overflow_flag_clr(overflow_flag_clr),
    .external_flag_clr(external_flag_clr),
    .trigger_direction_input(trigger_direction_input),
    .external_count_input(external_count_input),
    .timer1_overflow(timer1_overflow),
    .count_low_byte(count_low_byte), .count_high_byte(count_high_byte),
    .overflow_flag(overflow_flag), .external_flag(external_flag),
    .timer_irq(timer_irq), .timer2_overflow(timer2_overflow),
    .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick));

  ttrb_serial_model ttrb_serial_model_inst (
    .core_clk(core_clk), .rstn(rstn), .cnt_clr(cnt_clr),
    .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick),
    .timer1_overflow(timer1_overflow), .rx_seen(rx_seen),
    .tx_seen(tx_seen));

  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [15:0] inr(input int v, lo, hi);
    return (v >= lo && v <= hi) ? 16'h0001 : 16'h0000;
  endfunction

  // Controls are {dce, trig, ete, rsel, tsel, cts}; the count is written
  // only while stopped, and pins get time to pass the synchronisers.
  // stop before write
  task automatic setup(input logic [5:0] ctl, input logic [15:0] rld, pre);
    @(posedge core_clk);
    run_control <= 1'b0;
    {down_count_enable, trigger_direction_input, ext_trigger_enable,
     rx_clock_select, tx_clock_select, counter_timer_select} <= ctl;
    {reload_high_byte, reload_low_byte} <= rld;
    repeat (5) @(posedge core_clk);
    {count_wr_en, overflow_flag_clr, external_flag_clr} <= 3'h7;
    count_wr_data <= pre;
    @(posedge core_clk);
    {count_wr_en, overflow_flag_clr, external_flag_clr} <= 3'h0;
  endtask

  task automatic wait_step(output int cyc);
    logic [15:0] prev;
    prev = cnt;
    cyc  = 0;
    do begin
      @(negedge core_clk);
      cyc++;
    end while (cnt === prev && cyc < 60);
    if (cnt === prev) begin
      err_total++;
      $display("BAD count step expected change seen %h", cnt);
      test_done();
    end
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    check("reset count", cnt, 16'h0000);
    check("reset outs", {10'h000, overflow_flag, external_flag, timer_irq,
          timer2_overflow, rx_baud_tick, tx_baud_tick}, 16'h0000);
    @(posedge core_clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      setup({rows[i].dce, rows[i].trig, 4'h0}, rows[i].rld, rows[i].pre);
      run_control <= 1'b1;
      // Let the preset write settle so it is not mistaken for a step.
      @(negedge core_clk);
      wait_step(gap);
      check("next count", cnt, rows[i].nxt);
      check("flags", {14'h0, overflow_flag, external_flag},
            {14'h0, rows[i].ovf, rows[i].ext});
      check("irq", {15'h0, timer_irq}, {15'h0, rows[i].ovf});
      wait_step(gap);
      check("step gap", gap[15:0], 16'h000C);
      @(posedge core_clk);
      overflow_flag_clr <= 1'b1;
      @(posedge core_clk);
      overflow_flag_clr <= 1'b0;
      @(negedge core_clk);
      check("irq ext", {15'h0, timer_irq},
            {15'h0, rows[i].ext & ~rows[i].dce});
    end
    setup(6'h10, 16'h1234, 16'h0100);
    repeat (30) @(negedge core_clk);
    check("stopped count", cnt, 16'h0100);
    setup(6'h18, 16'h5555, 16'h0100);
    trigger_direction_input <= 1'b0;
    repeat (6) @(negedge core_clk);
    check("trig reload", cnt, 16'h5555);
    check("trig flags", {13'h0, overflow_flag, external_flag, timer_irq},
          16'h0003);
    setup(6'h11, 16'h1234, 16'h0000);
    run_control <= 1'b1;
    repeat (5) begin
      @(posedge core_clk);
      external_count_input <= 1'b0;
      repeat (4) @(posedge core_clk);
      external_count_input <= 1'b1;
      repeat (4) @(posedge core_clk);
    end
    repeat (6) @(negedge core_clk);
    check("event count", cnt, 16'h0005);
    setup(6'h1C, 16'hFFF0, 16'h1234);
    trigger_direction_input <= 1'b0;
    repeat (6) @(negedge core_clk);
    check("baud trig count", cnt, 16'h1234);
    check("baud trig ext", {15'h0, external_flag}, 16'h0001);
    // Each channel is measured once on each source over 3200 cycles.
    for (int i = 0; i < 2; i++) begin
      setup({3'h2, i == 0, i == 1, 1'b0}, 16'hFFF0, 16'hFFF0);
      run_control <= 1'b1;
      repeat (40) @(posedge core_clk);
      cnt_clr <= 1'b1;
      @(posedge core_clk);
      cnt_clr <= 1'b0;
      repeat (3200) @(posedge core_clk);
      @(negedge core_clk);
      check("t2 wraps", inr(n_t2, 99, 101), 16'h0001);
      check("rx ticks", inr(rx_seen, i ? 9 : 5, i ? 11 : 7),
            16'h0001);
      check("tx ticks", inr(tx_seen, i ? 5 : 9, i ? 7 : 11),
            16'h0001);
      check("baud ovf", {15'h0, overflow_flag}, 16'h0000);
      check("baud irq", {15'h0, timer_irq}, 16'h0000);
    end
    test_done();
  end
endmodule
